// ### ptr_regs.svh
// register offsets, field positions, reset values for pad test readback
`ifndef PTR_REGS_SVH
`define PTR_REGS_SVH
`define PTR_OFS_CONTROL_THREE 16'h0456
`define PTR_OFS_STATUS_LOW 16'h0457
`define PTR_OFS_STATUS_HIGH 16'h0458
`define PTR_SLEW_MSB 9
`define PTR_SLEW_LSB 5
`define PTR_RST_CONTROL_THREE 16'h0100
`define PTR_RST_SLEW 5'h08
`define PTR_RST_STATUS 16'h0000
`define PTR_STATUS_HIGH_USED 4
`endif

// ### ptr_pkg.sv
// types for pad test readback
package ptr_pkg;
	typedef enum logic [4:0] {
		PTR_SLEW_DEFAULT = 5'h08,
		PTR_SLEW_MEDIUM = 5'h0a,
		PTR_SLEW_SLOWEST = 5'h0b
	} ptr_slew_t;
	typedef logic [15:0] ptr_word_t;
endpackage

// ### ptr_pad_test_readback.sv
// pad test readback status registers and mac pad slew selector
`timescale 1ns/1ps
`include "ptr_regs.svh"

module ptr_pad_test_readback (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic pad_test_override,
	input wire logic pad_test_dir,
	output logic pad_test_drive_en,
	output logic pad_test_observe,
	output logic [4:0] mac_pad_slew,
	input wire logic indicator_pad_first,
	input wire logic indicator_pad_second,
	input wire logic clock_output_pad,
	input wire logic interrupt_pad,
	input wire logic inhibit_pad,
	input wire logic mac_transmit_clock,
	input wire logic mac_transmit_control,
	input wire logic mac_transmit_bit_zero,
	input wire logic mac_transmit_bit_one,
	input wire logic mac_transmit_bit_two,
	input wire logic mac_transmit_bit_three,
	input wire logic mac_receive_clock,
	input wire logic mac_receive_control,
	input wire logic mac_receive_bit_zero,
	input wire logic mac_receive_bit_one,
	input wire logic mac_receive_bit_two,
	input wire logic mac_receive_bit_three,
	input wire logic strap_pad_first
);

	// ==========================================================
	// decode
	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	logic [15:0] pad_test_control_three;
	ptr_pkg::ptr_word_t pad_level_status_low;
	ptr_pkg::ptr_word_t pad_level_status_high;

	wire hit_ctl = hit(reg_addr, `PTR_OFS_CONTROL_THREE);
	wire hit_low = hit(reg_addr, `PTR_OFS_STATUS_LOW);
	wire hit_high = hit(reg_addr, `PTR_OFS_STATUS_HIGH);
	wire ctl_we = reg_wr & hit_ctl;

	// ==========================================================
	// test mode direction
	// override plus inverted direction
	assign pad_test_drive_en = pad_test_override & ~pad_test_dir;
	// observe only when override and input
	assign pad_test_observe = pad_test_override & pad_test_dir;

	// ==========================================================
	// live pin maps
	// pin level straight into bit position
	wire [15:0] live_low = {mac_receive_bit_zero, mac_receive_control, mac_receive_clock,
		mac_transmit_bit_three, mac_transmit_bit_two, mac_transmit_bit_one,
		mac_transmit_bit_zero, mac_transmit_control, mac_transmit_clock, inhibit_pad,
		2'h0, interrupt_pad, clock_output_pad, indicator_pad_second, indicator_pad_first};
	wire [15:0] live_high = {12'h000, strap_pad_first, mac_receive_bit_three,
		mac_receive_bit_two, mac_receive_bit_one};

	// ==========================================================
	// registers
	// only the slew field is writable; other bits stay reserved zero
	wire [15:0] next_control_three = {6'h00, reg_wdata[`PTR_SLEW_MSB:`PTR_SLEW_LSB], 5'h00};
	wire [15:0] rd_mux = hit_ctl ? pad_test_control_three :
		hit_low ? pad_level_status_low :
		hit_high ? pad_level_status_high : 16'h0000;

	// slew selector, reset to default edges
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pad_test_control_three <= `PTR_RST_CONTROL_THREE;
		end else if (ctl_we) begin
			pad_test_control_three <= next_control_three;
		end
	end
	assign mac_pad_slew = pad_test_control_three[`PTR_SLEW_MSB:`PTR_SLEW_LSB];

	// status reset zero, hold last sample when not observing
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pad_level_status_low <= `PTR_RST_STATUS;
			pad_level_status_high <= `PTR_RST_STATUS;
		end else if (pad_test_observe) begin
			pad_level_status_low <= live_low;
			pad_level_status_high <= live_high;
		end
	end

	// read answer one cycle after the strobe; reads have no side effect
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'h0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rd_mux;
			end
		end
	end

	// ==========================================================
	// checks
	// bit checks name the pins directly, so a slip in the packed map shows up
	// slew default after reset
	a_slew_reset_value: assert property (@(posedge core_clk)
		rst |=> mac_pad_slew == `PTR_RST_SLEW)
		else $error("slew not default after reset");
	a_slew_write_takes: assert property (@(posedge core_clk) disable iff (rst)
		reg_wr && reg_addr == `PTR_OFS_CONTROL_THREE |=>
		mac_pad_slew == $past(reg_wdata[`PTR_SLEW_MSB:`PTR_SLEW_LSB]))
		else $error("slew write lost");
	a_ctl_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
		pad_test_control_three[15:10] == 6'h00 && pad_test_control_three[4:0] == 5'h00)
		else $error("control reserved bits set");
	a_slew_other_write: assert property (@(posedge core_clk) disable iff (rst)
		reg_wr && reg_addr != `PTR_OFS_CONTROL_THREE |=> $stable(mac_pad_slew))
		else $error("slew moved by foreign write");
	a_low_follows_pins: assert property (@(posedge core_clk) disable iff (rst)
		pad_test_override && pad_test_dir |=> pad_level_status_low == $past(live_low))
		else $error("status low not tracking pins");
	a_observe_needs_ovr: assert property (@(posedge core_clk) disable iff (rst)
		!pad_test_override |-> !pad_test_observe && !pad_test_drive_en)
		else $error("test direction active without override");
	a_low_holds_idle: assert property (@(posedge core_clk) disable iff (rst)
		!(pad_test_override && pad_test_dir) |=> $stable(pad_level_status_low))
		else $error("status low moved while idle");
	a_high_holds_idle: assert property (@(posedge core_clk) disable iff (rst)
		!(pad_test_override && pad_test_dir) |=> $stable(pad_level_status_high))
		else $error("status high moved while idle");
	a_pin_level_bit: assert property (@(posedge core_clk) disable iff (rst)
		pad_test_observe ##1 pad_test_observe |-> pad_level_status_low[6] == $past(inhibit_pad))
		else $error("inhibit bit wrong");
	a_indicator_place: assert property (@(posedge core_clk) disable iff (rst)
		pad_test_observe |=> pad_level_status_low[1:0] == $past({indicator_pad_second, indicator_pad_first}))
		else $error("indicator bit misplaced");
	a_clock_int_place: assert property (@(posedge core_clk) disable iff (rst)
		pad_test_observe |=> pad_level_status_low[3:2] == $past({interrupt_pad, clock_output_pad}))
		else $error("clock or interrupt bit misplaced");
	a_reserved_low_zero: assert property (@(posedge core_clk) disable iff (rst)
		pad_level_status_low[5:4] == 2'h0)
		else $error("reserved bits set");
	a_rx_bit_place: assert property (@(posedge core_clk) disable iff (rst)
		pad_test_observe |=> pad_level_status_low[15] == $past(mac_receive_bit_zero)
		&& pad_level_status_low[7] == $past(mac_transmit_clock))
		else $error("mac bit misplaced");
	a_tx_data_place: assert property (@(posedge core_clk) disable iff (rst)
		pad_test_observe |=> pad_level_status_low[12:8] == $past({mac_transmit_bit_three,
		mac_transmit_bit_two, mac_transmit_bit_one, mac_transmit_bit_zero, mac_transmit_control}))
		else $error("transmit bit misplaced");
	a_rx_ctl_place: assert property (@(posedge core_clk) disable iff (rst)
		pad_test_observe |=> pad_level_status_low[14:13] == $past({mac_receive_control, mac_receive_clock}))
		else $error("receive control misplaced");
	a_high_bit_place: assert property (@(posedge core_clk) disable iff (rst)
		pad_test_observe |=> pad_level_status_high[3:0] == $past({strap_pad_first,
		mac_receive_bit_three, mac_receive_bit_two, mac_receive_bit_one}))
		else $error("status high bit misplaced");
	a_high_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
		pad_level_status_high[15:4] == 12'h000)
		else $error("status high reserved set");
	a_status_reset_zero: assert property (@(posedge core_clk)
		rst |=> pad_level_status_low == `PTR_RST_STATUS && pad_level_status_high == `PTR_RST_STATUS)
		else $error("status not zero after reset");
	a_status_read_back: assert property (@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr == `PTR_OFS_STATUS_HIGH |=> reg_rdata == $past(pad_level_status_high))
		else $error("status high read wrong");
	a_low_read_back: assert property (@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr == `PTR_OFS_STATUS_LOW |=> reg_rdata == $past(pad_level_status_low))
		else $error("status low read wrong");
	a_unmapped_read_zero: assert property (@(posedge core_clk) disable iff (rst)
		reg_rd && reg_addr != `PTR_OFS_CONTROL_THREE && reg_addr != `PTR_OFS_STATUS_LOW
		&& reg_addr != `PTR_OFS_STATUS_HIGH |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_read_answer_next: assert property (@(posedge core_clk) disable iff (rst)
		1'h1 |=> reg_rvalid == $past(reg_rd))
		else $error("read answer timing wrong");
	a_rdata_holds_idle: assert property (@(posedge core_clk) disable iff (rst)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	a_drive_dir_excl: assert property (@(posedge core_clk) disable iff (rst)
		!(pad_test_drive_en && pad_test_observe)
		&& (pad_test_drive_en == (pad_test_override && !pad_test_dir)))
		else $error("direction select wrong");

endmodule

// ### ptr_pad_test_readback_tb.sv
// self-checking bench for pad test readback
`timescale 1ns/1ps
`include "ptr_regs.svh"
module ptr_pad_test_readback_tb;
	logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ovr = 0, dir = 0;
	logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
	logic reg_rvalid, drive_en, observe;
	logic [4:0] slew;
	logic [17:0] p = 18'h00000;
	logic [15:0] expq[$];
	logic [31:0] seed = 32'hf8abec14;
	ptr_pkg::ptr_slew_t codes[3] = '{ptr_pkg::PTR_SLEW_MEDIUM, ptr_pkg::PTR_SLEW_SLOWEST,
		ptr_pkg::PTR_SLEW_DEFAULT};
	int num_errors = 0, comparisons = 0;
	always #2 core_clk = ~core_clk;
	ptr_pad_test_readback dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .pad_test_override(ovr), .pad_test_dir(dir),
		.pad_test_drive_en(drive_en), .pad_test_observe(observe), .mac_pad_slew(slew),
		.indicator_pad_first(p[0]), .indicator_pad_second(p[1]), .clock_output_pad(p[2]),
		.interrupt_pad(p[3]), .inhibit_pad(p[4]), .mac_transmit_clock(p[5]),
		.mac_transmit_control(p[6]), .mac_transmit_bit_zero(p[7]), .mac_transmit_bit_one(p[8]),
		.mac_transmit_bit_two(p[9]), .mac_transmit_bit_three(p[10]), .mac_receive_clock(p[11]),
		.mac_receive_control(p[12]), .mac_receive_bit_zero(p[13]), .mac_receive_bit_one(p[14]),
		.mac_receive_bit_two(p[15]), .mac_receive_bit_three(p[16]), .strap_pad_first(p[17]));
	// ==========================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [15:0] lo(input logic [17:0] v);
		return {v[13:5], v[4], 2'b00, v[3:0]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_slew(input logic [4:0] got, input logic [4:0] exp);
		chk({11'h000, got}, {11'h000, exp});
	endtask
	task automatic chk_dir(input logic got_drive, input logic got_obs, input logic [1:0] exp);
		chk({14'h0000, got_drive, got_obs}, {14'h0000, exp});
	endtask
	// one idle cycle after each strobe so no signal is set twice in one step
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge core_clk) #1 reg_wr = 0;
		@(posedge core_clk) #1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		reg_addr = a;
		reg_rd = 1;
		expq.push_back(e);
		@(posedge core_clk) #1 reg_rd = 0;
		@(posedge core_clk) #1;
	endtask
	task automatic report_and_stop();
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ==========================================
	// read answer watcher
	always @(posedge core_clk) if (reg_rvalid === 1'b1) begin
		chk(reg_rdata, expq.size() > 0 ? expq.pop_front() : 16'hdead);
	end
	// ==========================================
	// main sequence
	initial begin
		logic [17:0] q;
		repeat (3) @(posedge core_clk);
		#1 rst = 0;
		rd(`PTR_OFS_STATUS_LOW, `PTR_RST_STATUS);
		rd(`PTR_OFS_STATUS_HIGH, `PTR_RST_STATUS);
		rd(`PTR_OFS_CONTROL_THREE, `PTR_RST_CONTROL_THREE);
		chk_slew(slew, ptr_pkg::PTR_SLEW_DEFAULT);
		foreach (codes[i]) begin
			wr(`PTR_OFS_CONTROL_THREE, {6'h3f, codes[i], 5'h1f});
			chk_slew(slew, codes[i]);
			rd(`PTR_OFS_CONTROL_THREE, {6'h00, codes[i], 5'h00});
		end
		ovr = 1;
		dir = 1;
		@(posedge core_clk) #1 chk_dir(drive_en, observe, 2'h1);
		repeat (4) begin
			seed = xs(seed);
			p = seed[17:0];
			@(posedge core_clk) #1;
			rd(`PTR_OFS_STATUS_LOW, lo(p));
			rd(`PTR_OFS_STATUS_HIGH, {12'h000, p[17:14]});
		end
		q = p;
		dir = 0;
		p = ~q;
		@(posedge core_clk) #1 chk_dir(drive_en, observe, 2'h2);
		rd(`PTR_OFS_STATUS_LOW, lo(q));
		ovr = 0;
		@(posedge core_clk) #1 chk_dir(drive_en, observe, 2'h0);
		// direction input alone must not start sampling
		dir = 1;
		@(posedge core_clk) #1 chk_dir(drive_en, observe, 2'h0);
		wr(`PTR_OFS_STATUS_LOW, ~lo(q));
		wr(`PTR_OFS_STATUS_HIGH, 16'hffff);
		rd(`PTR_OFS_STATUS_LOW, lo(q));
		rd(`PTR_OFS_STATUS_HIGH, {12'h000, q[17:14]});
		rd(16'h0459, 16'h0000);
		// mid-run reset after a non-default slew and held status
		seed = xs(seed);
		wr(`PTR_OFS_CONTROL_THREE, {seed[15:10], ptr_pkg::PTR_SLEW_SLOWEST, seed[4:0]});
		chk_slew(slew, ptr_pkg::PTR_SLEW_SLOWEST);
		rst = 1;
		@(posedge core_clk) #1 rst = 0;
		chk_slew(slew, ptr_pkg::PTR_SLEW_DEFAULT);
		rd(`PTR_OFS_STATUS_LOW, `PTR_RST_STATUS);
		rd(`PTR_OFS_CONTROL_THREE, `PTR_RST_CONTROL_THREE);
		for (int i = 0; i < 20 && expq.size() > 0; i++) @(posedge core_clk);
		if (expq.size() > 0) num_errors++;
		report_and_stop();
	end
endmodule
